// >>> core/odac_readback.sv
// two-wire target with register file for an eight-channel converter
// assumes an oversampling link clock far faster than the bus clock
// Notes on behaviour
// - read starts with write-direction address, acknowledged
// - command byte names register, acknowledged
// - repeated start with read address, acknowledged
// - upper data byte driven first
// - lower data byte follows after controller ack
// - read without command returns last written register
// - all registers readable except soft reset field
// - no answer to reads at broadcast address
// - codes 01h, 02h, 03h select config, identity, broadcast
// - codes 08h-0Fh select channels A to H
// - config bit 8 powers everything down
// - bits 7-0 per-channel power-down, reset all ones
// - config resets 00FFh, upper bits ignored
// - pattern 1010 in identity bits 3-0 resets all
// - codes in bits 11-2, 8-bit ignores two lsbs
// - broadcast write loads every channel at once
`timescale 1ns/1ps
module odac_readback #(
   parameter int CODE_BITS = 10,
   parameter logic [2:0] ADDR_LO = 3'h0,
   parameter logic [5:0] PART_ID = 6'h2a // arbitrary value
) (
   input wire logic clk_sys,
   input wire logic clk_link,
   input wire logic nrst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic [79:0] channel_code,
   output logic [7:0] channel_powerdown,
   output logic global_powerdown
);

   // -------------------------------------------------------------------
   // constants derived from parameters
   // -------------------------------------------------------------------
   localparam logic [9:0] CODE_MASK =
      (CODE_BITS == 8) ? odac_pkg::ODAC_MASK_8 : odac_pkg::ODAC_MASK_10;
   localparam logic [6:0] OWN_ADDR = {odac_pkg::ODAC_ADDR_BASE, ADDR_LO};

   // -------------------------------------------------------------------
   // state of both domains
   // -------------------------------------------------------------------
   typedef struct packed {
      odac_pkg::odac_state_t st; // link sequencer state
      logic [3:0] bitcnt; // bits moved in this byte
      logic [7:0] shreg; // shift register, both ways
      logic scl_p; // previous synced clock
      logic sda_p; // previous synced data
      logic rw; // direction of current frame
      logic mack; // controller ack sampled
      logic byteidx; // 0 upper byte, 1 lower byte
      logic [7:0] cmd; // command of this frame
      logic have_cmd; // command seen since address
      logic [7:0] last_cmd; // last register written
      logic [7:0] wmsb; // upper byte of a write
      logic [15:0] rdata; // read word from register side
      logic wait_rd; // read answer outstanding
      logic req_tgl; // request toggle
      logic req_wr; // request is a write
      logic [7:0] req_addr; // request register
      logic [15:0] req_data; // request write word
      logic sda_o; // pin output, always low
      logic sda_oe; // pulls the data line low
   } odac_link_t;

   typedef struct packed {
      logic [8:0] cfg; // power configuration bits
      logic [9:0] bcast; // all-channel code
      logic [7:0][9:0] chan; // channel codes
      logic req_d; // synced toggle, delayed
      logic ack_tgl; // answer toggle
      logic [15:0] rdata; // read word
   } odac_sys_t;

   odac_link_t link_r;
   odac_link_t link_nxt;
   odac_sys_t sys_r;
   odac_sys_t sys_nxt;
   logic [1:0] pins_s; // synced clock and data
   logic req_s; // synced request toggle
   logic ack_s; // synced answer toggle

   // -------------------------------------------------------------------
   // crossings
   // -------------------------------------------------------------------
   odac_sync2 #(.W(2)) u_pin_sync (
      .clk(clk_link), .nrst(nrst), .d({scl_in, sda_in}), .q(pins_s));
   odac_sync2 #(.W(1)) u_req_sync (
      .clk(clk_sys), .nrst(nrst), .d(link_r.req_tgl), .q(req_s));
   odac_sync2 #(.W(1)) u_ack_sync (
      .clk(clk_link), .nrst(nrst), .d(sys_r.ack_tgl), .q(ack_s));

   // -------------------------------------------------------------------
   // link-side events
   // -------------------------------------------------------------------
   wire scl_s = pins_s[1];
   wire sda_s = pins_s[0];
   wire scl_rise = scl_s & ~link_r.scl_p;
   wire scl_fall = ~scl_s & link_r.scl_p;
   wire bus_start = scl_s & link_r.scl_p & link_r.sda_p & ~sda_s;
   wire bus_stop = scl_s & link_r.scl_p & ~link_r.sda_p & sda_s;
   wire pend = link_r.req_tgl ^ ack_s;
   wire rx_state = (link_r.st == odac_pkg::ODAC_ADDR) |
                   (link_r.st == odac_pkg::ODAC_CMD) |
                   (link_r.st == odac_pkg::ODAC_WDATA);
   wire byte_done = scl_fall & (link_r.bitcnt == 4'h8);
   wire own_hit = link_r.shreg[7:1] == OWN_ADDR;
   wire bc_hit = (link_r.shreg[7:1] == odac_pkg::ODAC_ADDR_BCAST) &
                 ~link_r.shreg[0];

   // link sequencer next state
   always_comb
   begin
      link_nxt = link_r;
      link_nxt.scl_p = scl_s;
      link_nxt.sda_p = sda_s;
      // take the read word once the answer toggle is back
      if (link_r.wait_rd && !pend)
      begin
         link_nxt.rdata = sys_r.rdata;
         link_nxt.wait_rd = 1'b0;
      end
      // receive states shift on the rising clock
      if (rx_state && scl_rise)
      begin
         link_nxt.shreg = {link_r.shreg[6:0], sda_s};
         link_nxt.bitcnt = 4'(link_r.bitcnt + 4'h1);
      end
      if (bus_start)
      begin
         // start or repeated start: new address byte
         link_nxt.st = odac_pkg::ODAC_ADDR;
         link_nxt.bitcnt = 4'h0;
         link_nxt.sda_oe = 1'b0;
      end
      else if (bus_stop)
      begin
         // stop: release and forget the command
         link_nxt.st = odac_pkg::ODAC_IDLE;
         link_nxt.have_cmd = 1'b0;
         link_nxt.sda_oe = 1'b0;
      end
      else
      begin
         case (link_r.st)
            odac_pkg::ODAC_ADDR:
            begin
               if (byte_done)
               begin
                  link_nxt.bitcnt = 4'h0;
                  if (own_hit || bc_hit)
                  begin
                     link_nxt.sda_oe = 1'b1;
                     link_nxt.st = odac_pkg::ODAC_ADDR_ACK;
                     link_nxt.rw = link_r.shreg[0];
                     link_nxt.have_cmd = 1'b0;
                     if (link_r.shreg[0])
                     begin
                        // no command means last written register
                        link_nxt.req_addr = link_r.have_cmd ?
                                            link_r.cmd : link_r.last_cmd;
                        link_nxt.req_wr = 1'b0;
                        link_nxt.req_tgl = ~link_r.req_tgl;
                        link_nxt.wait_rd = 1'b1;
                     end
                  end
                  else
                     link_nxt.st = odac_pkg::ODAC_IDLE;
               end
            end
            odac_pkg::ODAC_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  link_nxt.bitcnt = 4'h0;
                  link_nxt.byteidx = 1'b0;
                  if (link_r.rw)
                  begin
                     link_nxt.shreg = link_r.rdata[15:8];
                     link_nxt.sda_oe = ~link_r.rdata[15];
                     link_nxt.st = odac_pkg::ODAC_RDATA;
                  end
                  else
                  begin
                     link_nxt.sda_oe = 1'b0;
                     link_nxt.st = odac_pkg::ODAC_CMD;
                  end
               end
            end
            odac_pkg::ODAC_CMD:
            begin
               // keep the command and acknowledge it
               if (byte_done)
               begin
                  link_nxt.cmd = link_r.shreg;
                  link_nxt.have_cmd = 1'b1;
                  link_nxt.sda_oe = 1'b1;
                  link_nxt.bitcnt = 4'h0;
                  link_nxt.byteidx = 1'b0;
                  link_nxt.st = odac_pkg::ODAC_CMD_ACK;
               end
            end
            odac_pkg::ODAC_CMD_ACK,
            odac_pkg::ODAC_WACK:
            begin
               if (scl_fall)
               begin
                  link_nxt.sda_oe = 1'b0;
                  link_nxt.st = odac_pkg::ODAC_WDATA;
                  if (link_r.st == odac_pkg::ODAC_WACK)
                  begin
                     link_nxt.byteidx = ~link_r.byteidx;
                     // word update at the falling edge of its ack
                     if (link_r.byteidx)
                     begin
                        link_nxt.req_wr = 1'b1;
                        link_nxt.req_addr = link_r.cmd;
                        link_nxt.req_data = {link_r.wmsb, link_r.shreg};
                        link_nxt.req_tgl = ~link_r.req_tgl;
                        link_nxt.last_cmd = link_r.cmd;
                     end
                  end
               end
            end
            odac_pkg::ODAC_WDATA:
            begin
               if (byte_done)
               begin
                  if (!link_r.byteidx)
                     link_nxt.wmsb = link_r.shreg;
                  link_nxt.sda_oe = 1'b1;
                  link_nxt.bitcnt = 4'h0;
                  link_nxt.st = odac_pkg::ODAC_WACK;
               end
            end
            odac_pkg::ODAC_RDATA:
            begin
               if (scl_fall)
               begin
                  if (link_r.bitcnt == 4'h7)
                  begin
                     // byte sent: release for the controller ack
                     link_nxt.sda_oe = 1'b0;
                     link_nxt.st = odac_pkg::ODAC_RACK;
                  end
                  else
                  begin
                     link_nxt.bitcnt = 4'(link_r.bitcnt + 4'h1);
                     link_nxt.shreg = {link_r.shreg[6:0], 1'b0};
                     link_nxt.sda_oe = ~link_r.shreg[6];
                  end
               end
            end
            odac_pkg::ODAC_RACK:
            begin
               if (scl_rise)
                  link_nxt.mack = sda_s;
               if (scl_fall)
               begin
                  link_nxt.bitcnt = 4'h0;
                  if (!link_r.mack)
                  begin
                     // other byte after an acked one: lower after upper, upper again after lower
                     link_nxt.byteidx = ~link_r.byteidx;
                     link_nxt.shreg = link_r.byteidx ?
                                      link_r.rdata[15:8] : link_r.rdata[7:0];
                     link_nxt.sda_oe = link_r.byteidx ?
                                       ~link_r.rdata[15] : ~link_r.rdata[7];
                     link_nxt.st = odac_pkg::ODAC_RDATA;
                  end
                  else
                     link_nxt.st = odac_pkg::ODAC_IDLE;
               end
            end
            default:
               link_nxt.st = odac_pkg::ODAC_IDLE;
         endcase
      end
   end

   // register link state
   always_ff @(posedge clk_link or negedge nrst)
   begin
      if (!nrst)
         link_r <= '0;
      else
         link_r <= link_nxt;
   end

   // -------------------------------------------------------------------
   // register side
   // -------------------------------------------------------------------
   wire sys_ev = req_s ^ sys_r.req_d;
   wire [9:0] wr_code = link_r.req_data[odac_pkg::ODAC_CODE_MSB:
                                         odac_pkg::ODAC_CODE_LSB] & CODE_MASK;
   wire chan_hit = link_r.req_addr[7:3] == odac_pkg::ODAC_CMD_CHAN0[7:3];

   // register file next state
   always_comb
   begin
      sys_nxt = sys_r;
      sys_nxt.req_d = req_s;
      if (sys_ev)
      begin
         sys_nxt.ack_tgl = ~sys_r.ack_tgl;
         if (link_r.req_wr)
         begin
            case (link_r.req_addr)
               odac_pkg::ODAC_CMD_CFG:
                  sys_nxt.cfg = link_r.req_data[8:0];
               odac_pkg::ODAC_CMD_ID:
               begin
                  if (link_r.req_data[3:0] == odac_pkg::ODAC_SRST_KEY)
                  begin
                     sys_nxt.cfg = odac_pkg::ODAC_CFG_RESET;
                     sys_nxt.bcast = odac_pkg::ODAC_CODE_RESET;
                     sys_nxt.chan = {8{odac_pkg::ODAC_CODE_RESET}};
                  end
               end
               odac_pkg::ODAC_CMD_BCAST:
               begin
                  sys_nxt.bcast = wr_code;
                  sys_nxt.chan = {8{wr_code}};
               end
               default:
               begin
                  if (chan_hit)
                     sys_nxt.chan[link_r.req_addr[2:0]] = wr_code;
               end
            endcase
         end
         else
         begin
            case (link_r.req_addr)
               odac_pkg::ODAC_CMD_CFG:
                  sys_nxt.rdata = {7'h00, sys_r.cfg};
               odac_pkg::ODAC_CMD_ID:
                  sys_nxt.rdata = {4'h0, PART_ID, 6'h00};
               odac_pkg::ODAC_CMD_BCAST:
                  sys_nxt.rdata = {4'h0, sys_r.bcast, 2'h0};
               default:
                  sys_nxt.rdata = chan_hit ?
                     {4'h0, sys_r.chan[link_r.req_addr[2:0]], 2'h0} : 16'h0000;
            endcase
         end
      end
   end

   // register file, power-up defaults
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         sys_r <= '0;
         sys_r.cfg <= odac_pkg::ODAC_CFG_RESET;
      end
      else
         sys_r <= sys_nxt;
   end

   // outputs straight from flip-flops
   assign sda_out = link_r.sda_o;
   assign sda_oe = link_r.sda_oe;
   assign channel_code = sys_r.chan;
   assign channel_powerdown = sys_r.cfg[7:0];
   assign global_powerdown = sys_r.cfg[odac_pkg::ODAC_GPD_BIT];

   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   wire wr_ev = sys_ev & link_r.req_wr;
   wire rd_ev = sys_ev & ~link_r.req_wr;

   addr_ack_a: assert property (@(posedge clk_link) disable iff (!nrst)
      (link_r.st == odac_pkg::ODAC_ADDR) && byte_done && own_hit && !bus_start
      && !bus_stop |=> sda_oe ##1 sda_oe [*1])
      else $error("own address not acknowledged");
   cmd_keep_a: assert property (@(posedge clk_link) disable iff (!nrst)
      (link_r.st == odac_pkg::ODAC_CMD) && byte_done && !bus_start && !bus_stop
      |=> link_r.have_cmd && sda_oe && (link_r.cmd == $past(link_r.shreg)))
      else $error("command byte not taken");
   bcast_rd_a: assert property (@(posedge clk_link) disable iff (!nrst)
      (link_r.st == odac_pkg::ODAC_ADDR) && byte_done && !bus_start &&
      !bus_stop && (link_r.shreg == {odac_pkg::ODAC_ADDR_BCAST, 1'b1})
      |=> !sda_oe && (link_r.st == odac_pkg::ODAC_IDLE))
      else $error("broadcast read answered");
   msb_first_a: assert property (@(posedge clk_link) disable iff (!nrst)
      (link_r.st == odac_pkg::ODAC_ADDR_ACK) && link_r.rw && scl_fall &&
      !bus_start && !bus_stop |=> sda_oe == ~link_r.rdata[15])
      else $error("upper data bit wrong");
   lsb_next_a: assert property (@(posedge clk_link) disable iff (!nrst)
      (link_r.st == odac_pkg::ODAC_RACK) && scl_fall && !link_r.mack &&
      !link_r.byteidx && !bus_start && !bus_stop
      |=> link_r.byteidx && (sda_oe == ~link_r.rdata[7]))
      else $error("lower data byte wrong");
   last_wr_a: assert property (@(posedge clk_link) disable iff (!nrst)
      (link_r.st == odac_pkg::ODAC_ADDR) && byte_done && own_hit &&
      link_r.shreg[0] && !link_r.have_cmd && !bus_start && !bus_stop
      |=> link_r.req_addr == link_r.last_cmd)
      else $error("shortcut read not last register");
   srst_all_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_ev && (link_r.req_addr == odac_pkg::ODAC_CMD_ID) &&
      (link_r.req_data[3:0] == odac_pkg::ODAC_SRST_KEY)
      |=> (sys_r.cfg == odac_pkg::ODAC_CFG_RESET) && (channel_code == '0))
      else $error("soft reset incomplete");
   bcast_load_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_ev && (link_r.req_addr == odac_pkg::ODAC_CMD_BCAST)
      |=> channel_code == {8{wr_code}})
      else $error("broadcast not loaded");
   chan_sel_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_ev && (link_r.req_addr == 8'h0a) |=> channel_code[29:20] == wr_code)
      else $error("channel code misplaced");
   cfg_pd_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_ev && (link_r.req_addr == odac_pkg::ODAC_CMD_CFG) |=>
      {global_powerdown, channel_powerdown} == link_r.req_data[8:0])
      else $error("power-down bits not stored");
   rd_id_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      rd_ev && (link_r.req_addr == odac_pkg::ODAC_CMD_ID)
      |=> sys_r.rdata == {4'h0, PART_ID, 6'h00})
      else $error("identity read wrong");
   rd_cfg_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      rd_ev && (link_r.req_addr == odac_pkg::ODAC_CMD_CFG)
      |=> sys_r.rdata[15:9] == 7'h00)
      else $error("config upper bits not zero");

   rd_frame_c: cover property (@(posedge clk_link) disable iff (!nrst)
      (link_r.st == odac_pkg::ODAC_RACK) && scl_fall && link_r.mack);
   wr_frame_c: cover property (@(posedge clk_sys) disable iff (!nrst)
      wr_ev && chan_hit);
   bcast_c: cover property (@(posedge clk_sys) disable iff (!nrst)
      wr_ev && (link_r.req_addr == odac_pkg::ODAC_CMD_BCAST));

endmodule // odac_readback

// >>> common/odac_pkg.sv
// constants for the eight-channel converter register access block
// assumes devices on a two-wire bus share a fixed upper address nibble
package odac_pkg;

   // -------------------------------------------------------------------
   // bus addressing
   // -------------------------------------------------------------------
   localparam logic [3:0] ODAC_ADDR_BASE = 4'h9; // fixed upper address bits
   localparam logic [6:0] ODAC_ADDR_BCAST = 7'h47; // shared write-only address

   // -------------------------------------------------------------------
   // command codes (register offsets)
   // -------------------------------------------------------------------
   localparam logic [7:0] ODAC_CMD_CFG = 8'h01; // power configuration
   localparam logic [7:0] ODAC_CMD_ID = 8'h02; // identity and soft reset
   localparam logic [7:0] ODAC_CMD_BCAST = 8'h03; // all-channel code
   localparam logic [7:0] ODAC_CMD_CHAN0 = 8'h08; // channel A, up to 0fh

   // -------------------------------------------------------------------
   // field positions and reset values
   // -------------------------------------------------------------------
   localparam int ODAC_GPD_BIT = 8; // global power-down bit
   localparam int ODAC_CODE_LSB = 2; // code field low bit
   localparam int ODAC_CODE_MSB = 11; // code field high bit
   localparam int ODAC_ID_LSB = 6; // identity field low bit
   localparam logic [8:0] ODAC_CFG_RESET = 9'h0ff; // all channels down
   localparam logic [9:0] ODAC_CODE_RESET = 10'h000; // code reset value
   localparam logic [3:0] ODAC_SRST_KEY = 4'ha; // soft reset pattern
   localparam logic [9:0] ODAC_MASK_10 = 10'h3ff; // 10-bit variant
   localparam logic [9:0] ODAC_MASK_8 = 10'h3fc; // 8-bit variant

   // -------------------------------------------------------------------
   // link-side states
   // -------------------------------------------------------------------
   typedef enum logic [3:0] {
      ODAC_IDLE = 4'b0000,
      ODAC_ADDR = 4'b0001,
      ODAC_ADDR_ACK = 4'b0010,
      ODAC_CMD = 4'b0011,
      ODAC_CMD_ACK = 4'b0100,
      ODAC_WDATA = 4'b0101,
      ODAC_WACK = 4'b0110,
      ODAC_RDATA = 4'b0111,
      ODAC_RACK = 4'b1000
   } odac_state_t;

endpackage

// >>> core/odac_sync2.sv
// two flip-flop level synchroniser, any width
// assumes each bit is a level or a slow toggle from another domain
`timescale 1ns/1ps
module odac_sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [W-1:0] s1; // first stage, read only by s2
      logic [W-1:0] s2; // second stage, safe to use
   } odac_sync_t;

   odac_sync_t sync_r;
   odac_sync_t sync_nxt;

   // shift the input along the chain
   always_comb
   begin
      sync_nxt = sync_r;
      sync_nxt.s1 = d;
      sync_nxt.s2 = sync_r.s1;
   end

   // register the chain
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         sync_r <= '0;
      else
         sync_r <= sync_nxt;
   end

   assign q = sync_r.s2;

endmodule // odac_sync2

// >>> tb/odac_i2c_ctrl.sv
// two-wire bus controller model facing the converter's target port
// assumes the testbench resolves sda from all open-drain drivers
`timescale 1ns/1ps
module odac_i2c_ctrl (
   output logic scl,
   output logic sda_drv,
   input wire logic sda
);
   // bus idles released, clock stands high between frames
   initial
   begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // one bit: data set while scl low, sampled in the high phase
   task automatic bit_io(input logic b, output logic r);
      sda_drv = b;
      #80 scl = 1'b1;
      #160 r = sda;
      scl = 1'b0;
      #80;
   endtask
   task automatic start();
      sda_drv = 1'b1;
      #80 scl = 1'b1;
      #160 sda_drv = 1'b0;
      #160 scl = 1'b0;
      #80;
   endtask
   // ninth bit carries the ack given or taken
   task automatic xfer(input logic [7:0] d, input logic m,
                       output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(m, a);
   endtask
   task automatic stop();
      sda_drv = 1'b0;
      #80 scl = 1'b1;
      #160 sda_drv = 1'b1;
      #160;
   endtask
endmodule // odac_i2c_ctrl

// >>> tb/tb_octal_dac_i2c_register_readback.sv
// self-checking bench for the converter register access block
// assumes a 10-bit target at 1001000 and an 8-bit one at 1001001
`timescale 1ns/1ps
module tb_octal_dac_i2c_register_readback;
   logic clk_sys, clk_link, nrst, scl, sda_drv, sda_oe, sda_out, gpd;
   logic [79:0] code;
   logic [7:0] pd;
   logic sda_oe8, sda_out8;
   logic [79:0] code8;
   logic [7:0] dev_ad; // write-direction address byte used by wr and rd
   // pulled-up wire, both targets pull low
   wire sda = sda_drv & ~(sda_oe & ~sda_out) & ~(sda_oe8 & ~sda_out8);
   int miscompares, n_tests;
   odac_readback uut (.clk_sys(clk_sys), .clk_link(clk_link), .nrst(nrst),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .channel_code(code), .channel_powerdown(pd), .global_powerdown(gpd));
   // second target: 8-bit codes at the next address
   odac_readback #(.CODE_BITS(8), .ADDR_LO(3'h1)) uut8 (.clk_sys(clk_sys),
      .clk_link(clk_link), .nrst(nrst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out8), .sda_oe(sda_oe8), .channel_code(code8),
      .channel_powerdown(), .global_powerdown());
   odac_i2c_ctrl ctrl (.scl(scl), .sda_drv(sda_drv), .sda(sda));
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial
   begin
      clk_link = 1'b0;
      #3.1;
      forever #7.5 clk_link = ~clk_link;
   end
   task automatic check(input string nm, input logic [15:0] got, exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one byte written, acknowledge compared
   task automatic put(input logic [7:0] d, input logic e);
      logic [7:0] q;
      logic a;
      ctrl.xfer(d, 1'b1, q, a);
      check("ack", {15'h0000, a}, {15'h0000, e});
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
      ctrl.start();
      put(dev_ad, 1'b0);
      put(cmd, 1'b0);
      put(d[15:8], 1'b0);
      put(d[7:0], 1'b0);
      ctrl.stop();
   endtask
   // command 00 means the shortcut read with no command byte
   task automatic rd(input logic [7:0] cmd, input logic [15:0] e);
      logic [15:0] q;
      logic a;
      ctrl.start();
      if (cmd != 8'h00)
      begin
         put(dev_ad, 1'b0);
         put(cmd, 1'b0);
         ctrl.start();
      end
      put(dev_ad | 8'h01, 1'b0);
      ctrl.xfer(8'hff, 1'b0, q[15:8], a);
      ctrl.xfer(8'hff, 1'b1, q[7:0], a);
      ctrl.stop();
      check("read", q, e);
   endtask
   task automatic t_reset();
      check("pd", {8'h00, pd}, 16'h00ff);
      check("gpd", {15'h0000, gpd}, 16'h0000);
      rd(8'h01, 16'h00ff);
   endtask
   task automatic t_chan();
      for (int i = 0; i < 8; i++)
      begin
         wr(8'h08 + 8'(i), {4'hf, 10'(i * 37 + 5), 2'b11});
         check("code", {6'h00, code[i*10 +: 10]}, 16'(i * 37 + 5));
         rd(8'h08 + 8'(i), {4'h0, 10'(i * 37 + 5), 2'b00});
      end
   endtask
   task automatic t_cfg();
      wr(8'h01, 16'hf15a);
      check("pd", {8'h00, pd}, 16'h005a);
      check("gpd", {15'h0000, gpd}, 16'h0001);
      rd(8'h00, 16'h015a);
   endtask
   task automatic t_bcast();
      wr(8'h03, 16'h0abc);
      for (int i = 0; i < 8; i++)
         check("bcast", {6'h00, code[i*10 +: 10]}, 16'h02af);
      rd(8'h03, 16'h0abc);
      rd(8'h02, 16'h0a80);
   endtask
   // broadcast address write reaches both, 8-bit target drops two lsbs
   task automatic t_var8();
      dev_ad = 8'h8e;
      wr(8'h03, 16'h0557);
      check("code", {6'h00, code[9:0]}, 16'h0155);
      check("code8", {6'h00, code8[79:70]}, 16'h0154);
      dev_ad = 8'h92;
      rd(8'h09, 16'h0550);
      dev_ad = 8'h90;
   endtask
   task automatic t_refuse();
      ctrl.start();
      put(8'h8f, 1'b1);
      ctrl.stop();
      wr(8'h02, 16'hfffa);
      check("pd", {8'h00, pd}, 16'h00ff);
      check("code", code[15:0], 16'h0000);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // hang guard
   initial
   begin
      #500000;
      miscompares++;
      tally_and_finish();
   end
   initial
   begin
      miscompares = 0;
      n_tests = 0;
      dev_ad = 8'h90;
      nrst = 1'b0;
      repeat (6) @(negedge clk_sys);
      nrst = 1'b1;
      #200;
      t_reset();
      t_chan();
      t_cfg();
      t_bcast();
      t_var8();
      t_refuse();
      tally_and_finish();
   end
endmodule // tb_octal_dac_i2c_register_readback
